/* shared/ses_pkg.sv */
// package of constants and types for the standard event status block
package ses_pkg;
  localparam int unsigned ES_W      = 8;
  localparam int unsigned BIT_OPC   = 0;
  localparam int unsigned BIT_QYE   = 2;
  localparam int unsigned BIT_DDE   = 3;
  localparam int unsigned BIT_EXE   = 4;
  localparam int unsigned BIT_CME   = 5;
  localparam int unsigned BIT_PON   = 7;
  localparam int unsigned STB_ESB   = 5;
  localparam logic [7:0]  USED_MASK = 8'hbd;
  localparam logic [7:0]  ZERO8     = 8'h00;
  localparam logic [7:0]  PON_RST   = 8'h80;
  typedef enum logic [2:0] {
    SES_NOP, SES_CLS, SES_ESE_WR, SES_ESE_RD, SES_ESR_RD, SES_OPC, SES_OPCQ
  } ses_cmd_t;
  typedef enum {SES_IDLE, SES_WAIT_EVT, SES_WAIT_Q} ses_opc_st_t;
endpackage : ses_pkg

/* shared/ses_opc_if.sv */
// interface between the status bank and the operation-complete tracker
`timescale 1ns/100ps
interface ses_opc_if;
  logic arm_evt;
  logic arm_q;
  logic cancel;
  logic done_evt;
  logic done_q;
  modport bank (output arm_evt, arm_q, cancel, input done_evt, done_q);
  modport trk  (input arm_evt, arm_q, cancel, output done_evt, done_q);
endinterface : ses_opc_if

/* src/ses_opc_trk.sv */
// operation-complete tracker armed by opc commands
`timescale 1ns/100ps
module ses_opc_trk (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic sw_busy,
  ses_opc_if.trk    op
);
  ses_pkg::ses_opc_st_t st_q, st_d;
  logic evt_d, evt_q, q_d, q_q;

  always_comb begin
    st_d  = st_q;
    evt_d = 1'b0;
    q_d   = 1'b0;
    case (st_q)
      ses_pkg::SES_IDLE: begin
        if (op.arm_evt) st_d = ses_pkg::SES_WAIT_EVT;
        else if (op.arm_q) st_d = ses_pkg::SES_WAIT_Q;
      end
      ses_pkg::SES_WAIT_EVT: begin
        if (!sw_busy) begin
          evt_d = 1'b1; // R17
          st_d  = ses_pkg::SES_IDLE;
        end
      end
      ses_pkg::SES_WAIT_Q: begin
        if (!sw_busy) begin
          q_d  = 1'b1;
          st_d = ses_pkg::SES_IDLE;
        end
      end
      default: st_d = ses_pkg::SES_IDLE;
    endcase
    if (op.cancel) begin
      st_d  = ses_pkg::SES_IDLE; // R2
      evt_d = 1'b0;
      q_d   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q  <= ses_pkg::SES_IDLE;
      evt_q <= 1'b0;
      q_q   <= 1'b0;
    end else begin
      st_q  <= st_d;
      evt_q <= evt_d;
      q_q   <= q_d;
    end
  end

  assign op.done_evt = evt_q;
  assign op.done_q   = q_q;

  a_cancel_clears: assert property (@(posedge clk) disable iff (!rstn)
    op.cancel |=> (st_q == ses_pkg::SES_IDLE) && !evt_q) // R2
    else $error("cancel did not drop pending opc");
  a_opc_fires: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == ses_pkg::SES_WAIT_EVT && !sw_busy && !op.cancel) |=> evt_q)
    else $error("opc event not raised after switching ended"); // R17
endmodule : ses_opc_trk

/* src/ses_err_q.sv */
// device-defined error queue: counts pending errors, emptied on clear
`timescale 1ns/100ps
module ses_err_q (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic       clr,
  output logic [3:0]      count
);
  logic [3:0] cnt_d, cnt_q;
  always_comb begin
    cnt_d = cnt_q;
    if (clr) cnt_d = 4'h0; // R1
    else if (push && !pop && cnt_q != 4'hf) cnt_d = cnt_q + 4'h1;
    else if (pop && !push && cnt_q != 4'h0) cnt_d = cnt_q - 4'h1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_q <= 4'h0;
    else cnt_q <= cnt_d;
  end
  assign count = cnt_q;
  a_errq_empty: assert property (@(posedge clk) disable iff (!rstn)
    clr |=> cnt_q == 4'h0) else $error("error queue not emptied"); // R1
endmodule : ses_err_q

/* src/ses_status_bank.sv */
// standard event status register bank with enable mask and clear logic
// Summary of operation
// [R1] clear command empties every status structure including the error queue
// [R2] clear command cancels any pending operation-complete request
// [R3] clear right after a terminator also empties output queue and flag
// [R4] enable write loads mask; ones enable matching event bits
// [R5] controller sends mask values only from 0 to 255
// [R6] enable query returns the present mask value; answers 01 instead when an opc query finishes in the same cycle
// [R7] event query returns the weights of all set event bits; answers 01 instead when an opc query finishes in the same cycle
// [R8] event register zeroed by clear and right after its query
// [R9] bit 7 set on power-on transition
// [R10] bit 5 set on command error
// [R11] bit 4 set on execution error
// [R12] bit 3 set on device-dependent error
// [R13] bit 2 set on query error
// [R14] bit 0 shows operation complete
// [R15] bits 6 and 1 always read zero; their mask bits do nothing
// [R16] status byte bit 5 high when an enabled event occurred
// [R17] opc sets bit 0 once running switching operations finish
// [R18] summary is or of event bits anded with mask, tracking both registers
`timescale 1ns/100ps
module ses_status_bank (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             cmd_vld,
  input  wire ses_pkg::ses_cmd_t cmd,
  input  wire logic [7:0]       cmd_data,
  input  wire logic             after_term,
  input  wire logic             cmd_err,
  input  wire logic             exe_err,
  input  wire logic             dev_err,
  input  wire logic             qry_err,
  input  wire logic             sw_busy,
  input  wire logic             err_push,
  input  wire logic             err_pop,
  output logic                  rsp_vld,
  output logic [7:0]            rsp_data,
  output logic                  out_q_clr,
  output logic                  mav_clr,
  output logic                  esb,
  output logic [3:0]            err_count
);
  ses_opc_if opif ();

  logic [7:0] ese_q, ese_d, esr_q, esr_d, set_v;
  logic       rsp_vld_d, oq_d, mav_d, esb_d, cls;
  logic [7:0] rsp_d;
  logic [3:0] cnt_w;

  function automatic logic [7:0] used(input logic [7:0] v);
    return v & ses_pkg::USED_MASK; // R15
  endfunction : used

  assign cls = cmd_vld && cmd == ses_pkg::SES_CLS;
  assign opif.arm_evt = cmd_vld && cmd == ses_pkg::SES_OPC;
  assign opif.arm_q   = cmd_vld && cmd == ses_pkg::SES_OPCQ;
  assign opif.cancel  = cls; // R2

  ses_opc_trk u_trk (
    .clk     (clk),
    .rstn    (rstn),
    .sw_busy (sw_busy),
    .op      (opif)
  );

  ses_err_q u_errq (
    .clk   (clk),
    .rstn  (rstn),
    .push  (err_push),
    .pop   (err_pop),
    .clr   (cls), // R1
    .count (cnt_w)
  );

  always_comb begin
    set_v = ses_pkg::ZERO8;
    set_v[ses_pkg::BIT_CME] = cmd_err;          // R10
    set_v[ses_pkg::BIT_EXE] = exe_err;          // R11
    set_v[ses_pkg::BIT_DDE] = dev_err;          // R12
    set_v[ses_pkg::BIT_QYE] = qry_err;          // R13
    set_v[ses_pkg::BIT_OPC] = opif.done_evt;    // R14
  end

  always_comb begin
    ese_d     = ese_q;
    esr_d     = esr_q;
    rsp_vld_d = 1'b0;
    rsp_d     = ses_pkg::ZERO8;
    oq_d      = 1'b0;
    mav_d     = 1'b0;
    if (cmd_vld) begin
      case (cmd)
        ses_pkg::SES_CLS: begin
          esr_d = ses_pkg::ZERO8; // R8
          oq_d  = after_term;     // R3
          mav_d = after_term;     // R3
        end
        ses_pkg::SES_ESE_WR: ese_d = cmd_data; // R4
        ses_pkg::SES_ESE_RD: begin
          rsp_vld_d = 1'b1;
          rsp_d     = ese_q; // R6
        end
        ses_pkg::SES_ESR_RD: begin
          rsp_vld_d = 1'b1;
          rsp_d     = used(esr_q); // R7
          esr_d     = ses_pkg::ZERO8; // R8
        end
        default: ;
      endcase
    end
    if (opif.done_q) begin
      rsp_vld_d = 1'b1;
      rsp_d     = 8'h01;
    end
    // events arriving with a clear or read are kept
    esr_d = used(esr_d | set_v);
    esb_d = |(used(esr_d) & ese_d); // R16 R18
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ese_q     <= ses_pkg::ZERO8;
      esr_q     <= ses_pkg::PON_RST; // R9
      rsp_vld   <= 1'b0;
      rsp_data  <= ses_pkg::ZERO8;
      out_q_clr <= 1'b0;
      mav_clr   <= 1'b0;
      esb       <= 1'b0;
      err_count <= 4'h0;
    end else begin
      ese_q     <= ese_d;
      esr_q     <= esr_d;
      rsp_vld   <= rsp_vld_d;
      rsp_data  <= rsp_d;
      out_q_clr <= oq_d;
      mav_clr   <= mav_d;
      esb       <= esb_d;
      err_count <= cnt_w;
    end
  end

  sequence s_esr_read;
    cmd_vld && cmd == ses_pkg::SES_ESR_RD;
  endsequence
  a_esr_rd_clear: assert property (@(posedge clk) disable iff (!rstn)
    s_esr_read ##0 (set_v == ses_pkg::ZERO8) |=> esr_q == ses_pkg::ZERO8)
    else $error("event register not cleared after read"); // R8
  a_esr_rd_value: assert property (@(posedge clk) disable iff (!rstn)
    s_esr_read ##0 !opif.done_q |=> rsp_vld && rsp_data == $past(esr_q))
    else $error("event query returned wrong value"); // R7
  a_ese_roundtrip: assert property (@(posedge clk) disable iff (!rstn)
    cmd_vld && cmd == ses_pkg::SES_ESE_WR ##1
    cmd_vld && cmd == ses_pkg::SES_ESE_RD && !opif.done_q
    |=> rsp_data == $past(cmd_data, 2))
    else $error("mask readback mismatch"); // R4
  a_unused_zero: assert property (@(posedge clk) disable iff (!rstn)
    (esr_q & ~ses_pkg::USED_MASK) == ses_pkg::ZERO8)
    else $error("unused event bit set"); // R15
  a_cls_term: assert property (@(posedge clk) disable iff (!rstn)
    cls |=> out_q_clr == $past(after_term) && mav_clr == $past(after_term))
    else $error("output queue clear wrong"); // R3
  a_cmd_err_set: assert property (@(posedge clk) disable iff (!rstn)
    cmd_err |=> esr_q[ses_pkg::BIT_CME])
    else $error("command error bit not set"); // R10
  a_esb_track: assert property (@(posedge clk) disable iff (!rstn)
    ##1 esb == |(esr_q & ese_q))
    else $error("summary flag mismatch"); // R16

  // each error or opc-done pulse must leave its own event bit set one cycle later
  a_exe_err_set: assert property (@(posedge clk) disable iff (!rstn)
    exe_err |=> esr_q[ses_pkg::BIT_EXE])
    else $error("execution error bit not set"); // R11
  a_dev_err_set: assert property (@(posedge clk) disable iff (!rstn)
    dev_err |=> esr_q[ses_pkg::BIT_DDE])
    else $error("device error bit not set"); // R12
  a_qry_err_set: assert property (@(posedge clk) disable iff (!rstn)
    qry_err |=> esr_q[ses_pkg::BIT_QYE])
    else $error("query error bit not set"); // R13
  a_opc_bit_set: assert property (@(posedge clk) disable iff (!rstn)
    opif.done_evt |=> esr_q[ses_pkg::BIT_OPC])
    else $error("operation complete bit not set"); // R14

  // a mask read answers with the mask held at the query edge
  sequence s_mask_read;
    cmd_vld && cmd == ses_pkg::SES_ESE_RD && !opif.done_q;
  endsequence
  a_mask_rd_value: assert property (@(posedge clk) disable iff (!rstn)
    s_mask_read |=> rsp_vld && rsp_data == $past(ese_q))
    else $error("mask query returned wrong value"); // R6

  // clear without a same-cycle event leaves the register empty
  a_cls_clears: assert property (@(posedge clk) disable iff (!rstn)
    cls && set_v == ses_pkg::ZERO8 |=> esr_q == ses_pkg::ZERO8)
    else $error("event register not cleared by clear"); // R8

  // no answer appears unless a command or a finished opc query came one cycle before
  a_rsp_cause: assert property (@(posedge clk) disable iff (!rstn)
    rsp_vld |-> $past(opif.done_q) || $past(cmd_vld))
    else $error("response without a query"); // R6 R7

  // the output queue clear strobe only ever follows a clear command
  a_oq_only_cls: assert property (@(posedge clk) disable iff (!rstn)
    out_q_clr |-> $past(cls))
    else $error("output queue cleared without clear command"); // R3

  // the error count output follows the queue one cycle late
  a_errq_follow: assert property (@(posedge clk) disable iff (!rstn)
    ##1 err_count == $past(cnt_w))
    else $error("error count output stale"); // R1
endmodule : ses_status_bank

/* bench/ses_ctrl_model.sv */
// remote controller model issuing common commands
`timescale 1ns/100ps
module ses_ctrl_model (
  input  wire logic        clk,
  output ses_pkg::ses_cmd_t cmd,
  output logic             cmd_vld,
  output logic [7:0]       cmd_data,
  output logic             after_term
);
  initial begin
    cmd_vld    = 1'b0;
    cmd        = ses_pkg::SES_NOP;
    cmd_data   = 8'h00;
    after_term = 1'b0;
  end
  // idle data shows the inverse so a stale byte is never reused
  task automatic send(input ses_pkg::ses_cmd_t c, input logic [7:0] d,
                      input logic t);
    @(posedge clk);
    cmd_vld    <= 1'b1;
    cmd        <= c;
    cmd_data   <= d;
    after_term <= t;
    @(posedge clk);
    cmd_vld    <= 1'b0;
    cmd        <= ses_pkg::SES_NOP;
    cmd_data   <= ~d;
    after_term <= ~t;
  endtask : send
endmodule : ses_ctrl_model

/* bench/ses_status_bank_tb_top.sv */
// self-checking bench for the standard event status bank
`timescale 1ns/100ps
module ses_status_bank_tb_top;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic             sw_busy = 1'b0;
  logic [3:0]       errs = 4'h0;
  logic [1:0]       eq = 2'h0;
  logic             cmd_vld, after_term, rsp_vld, out_q_clr, mav_clr, esb;
  logic [7:0]       cmd_data, rsp_data;
  logic [3:0]       err_count;
  ses_pkg::ses_cmd_t cmd;
  int               n_mismatch = 0;
  int               cmp_count = 0;
  always #25 clk = ~clk;
  ses_ctrl_model ses_ctrl_model_i (.clk(clk), .cmd(cmd), .cmd_vld(cmd_vld),
    .cmd_data(cmd_data), .after_term(after_term));
  ses_status_bank ses_status_bank_i (.clk(clk), .rstn(rstn),
    .cmd_vld(cmd_vld), .cmd(cmd), .cmd_data(cmd_data),
    .after_term(after_term), .cmd_err(errs[3]), .exe_err(errs[2]),
    .dev_err(errs[1]), .qry_err(errs[0]), .sw_busy(sw_busy),
    .err_push(eq[1]), .err_pop(eq[0]), .rsp_vld(rsp_vld),
    .rsp_data(rsp_data), .out_q_clr(out_q_clr), .mav_clr(mav_clr),
    .esb(esb), .err_count(err_count));
  task automatic tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic qry(input ses_pkg::ses_cmd_t c, input logic [7:0] exp);
    ses_ctrl_model_i.send(c, 8'h00, 1'b0);
    #1;
    cmp({7'h00, rsp_vld}, 8'h01);
    cmp(rsp_data, exp);
  endtask : qry
  task automatic hit(input logic [3:0] e, input logic [1:0] q);
    @(posedge clk);
    errs <= e;
    eq   <= q;
    @(posedge clk);
    errs <= 4'h0;
    eq   <= 2'h0;
  endtask : hit
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    qry(ses_pkg::SES_ESR_RD, ses_pkg::PON_RST);
    qry(ses_pkg::SES_ESR_RD, 8'h00);
    ses_ctrl_model_i.send(ses_pkg::SES_ESE_WR, 8'hff, 1'b0);
    qry(ses_pkg::SES_ESE_RD, 8'hff);
    for (int k = 0; k < 4; k++) begin
      hit(4'h1 << k, 2'h0);
      wt(2);
      cmp({7'h00, esb}, 8'h01);
      qry(ses_pkg::SES_ESR_RD, 8'h04 << k);
    end
    ses_ctrl_model_i.send(ses_pkg::SES_ESE_WR, 8'h42, 1'b0);
    hit(4'hf, 2'h0);
    wt(2);
    cmp({7'h00, esb}, 8'h00);
    ses_ctrl_model_i.send(ses_pkg::SES_ESE_WR, 8'h20, 1'b0);
    wt(2);
    cmp({7'h00, esb}, 8'h01);
    qry(ses_pkg::SES_ESR_RD, 8'h3c);
    @(posedge clk);
    sw_busy <= 1'b1;
    ses_ctrl_model_i.send(ses_pkg::SES_OPC, 8'h00, 1'b0);
    wt(4);
    qry(ses_pkg::SES_ESR_RD, 8'h00);
    @(posedge clk);
    sw_busy <= 1'b0;
    wt(4);
    qry(ses_pkg::SES_ESR_RD, 8'h01);
    @(posedge clk);
    sw_busy <= 1'b1;
    ses_ctrl_model_i.send(ses_pkg::SES_OPCQ, 8'h00, 1'b0);
    wt(3);
    cmp({7'h00, rsp_vld}, 8'h00);
    @(posedge clk);
    sw_busy <= 1'b0;
    for (int i = 0; i < 20 && rsp_vld !== 1'b1; i++) begin
      wt(1);
    end
    cmp(rsp_data, 8'h01);
    @(posedge clk);
    sw_busy <= 1'b1;
    ses_ctrl_model_i.send(ses_pkg::SES_OPC, 8'h00, 1'b0);
    hit(4'hf, 2'h2);
    hit(4'h0, 2'h2);
    hit(4'h0, 2'h1);
    wt(1);
    cmp({4'h0, err_count}, 8'h01);
    ses_ctrl_model_i.send(ses_pkg::SES_CLS, 8'h00, 1'b1);
    #1;
    cmp({6'h00, out_q_clr, mav_clr}, 8'h03);
    @(posedge clk);
    sw_busy <= 1'b0;
    wt(4);
    cmp({4'h0, err_count}, 8'h00);
    qry(ses_pkg::SES_ESR_RD, 8'h00);
    ses_ctrl_model_i.send(ses_pkg::SES_CLS, 8'h00, 1'b0);
    #1;
    cmp({6'h00, out_q_clr, mav_clr}, 8'h00);
    tally_and_finish();
  end
endmodule : ses_status_bank_tb_top
